// file: rtl/dasr_top.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

// Functional notes
// (RULE_01) Bit 15 of a word selects direction: 0 read, 1 write.
// (RULE_02) Bits 14..9 carry the six-bit address of the target register.
// (RULE_03) Return flag clear: advance to next entry when conversion completes.
// (RULE_04) Return flag set: go back to first entry when conversion completes.
// (RULE_05) Bits 7..4 choose the channel converter B samples for the entry.
// (RULE_06) Bits 3..0 choose the channel converter A samples for the entry.
// (RULE_07) Entry one sits at 0x21 and resets to 0x4211.
// (RULE_08) Entry two sits at 0x22 and resets to 0x4422.
// (RULE_09) Entry three sits at 0x23 and resets to 0x4633.
// (RULE_10) First entry sits at 0x20, same layout, resets to 0x4000.
// (RULE_11) Entries run in ascending order, starting at the first after reset.
module dasr_top
  import dasr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic conv_done,
  output logic [1:0] entry_index,
  output logic stack_return_flag,
  output logic [3:0] converter_a_channel,
  output logic [3:0] converter_b_channel
);

  localparam logic [5:0] ADDR_TAB [DASR_ENTRIES] = '{
    DASR_ADDR_ENTRY0, DASR_ADDR_ENTRY1, DASR_ADDR_ENTRY2, DASR_ADDR_ENTRY3
  };
  localparam logic [15:0] RST_TAB [DASR_ENTRIES] = '{
    DASR_RST_ENTRY0, DASR_RST_ENTRY1, DASR_RST_ENTRY2, DASR_RST_ENTRY3
  };

  logic [8:0] entry_q [DASR_ENTRIES];
  logic [8:0] next_entry [DASR_ENTRIES];
  logic [DASR_ENTRIES-1:0] addr_hit;
  logic wr_ok;
  logic [1:0] hit_idx;
  logic [15:0] next_rdata;
  logic [1:0] next_index;
  logic next_return;
  logic [3:0] next_cha;
  logic [3:0] next_chb;

  // Only a write word that names its own register is stored
  always_comb begin
    wr_ok = reg_wr && reg_wdata[DASR_DIR_BIT] && // RULE_01
      (reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == reg_addr); // RULE_02
  end

  genvar gi;
  generate
    for (gi = 0; gi < DASR_ENTRIES; gi++) begin : g_entry
      always_comb begin
        addr_hit[gi] = (reg_addr == ADDR_TAB[gi]); // RULE_07 RULE_08
        if (wr_ok && addr_hit[gi]) begin
          next_entry[gi] = reg_wdata[DASR_RET_BIT:0]; // RULE_05 RULE_06
        end else begin
          next_entry[gi] = entry_q[gi];
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          entry_q[gi] <= RST_TAB[gi][DASR_RET_BIT:0]; // RULE_09 RULE_10
        end else begin
          entry_q[gi] <= next_entry[gi];
        end
      end
    end
  endgenerate

  // Read path: direction bit reads 0, address field shows the register
  always_comb begin
    hit_idx = 2'h0;
    for (int i = 0; i < DASR_ENTRIES; i++) begin
      if (addr_hit[i]) begin
        hit_idx = 2'(i);
      end
    end
    next_rdata = DASR_RDATA_NONE;
    if (reg_rd && (|addr_hit)) begin
      next_rdata = {1'b0, reg_addr, entry_q[hit_idx]}; // RULE_01 RULE_02
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= DASR_RDATA_NONE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Sequencer: the index wraps from the last entry back to the first
  always_comb begin
    next_index = entry_index;
    if (conv_done) begin
      if (entry_q[entry_index][DASR_RET_BIT]) begin
        next_index = 2'h0; // RULE_04
      end else begin
        next_index = 2'(entry_index + 2'h1); // RULE_03 RULE_11
      end
    end
    next_return = next_entry[next_index][DASR_RET_BIT];
    next_chb = next_entry[next_index][DASR_CHB_MSB:DASR_CHB_LSB]; // RULE_05
    next_cha = next_entry[next_index][DASR_CHA_MSB:DASR_CHA_LSB]; // RULE_06
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      entry_index <= 2'h0; // RULE_11
      stack_return_flag <= DASR_RST_ENTRY0[DASR_RET_BIT];
      converter_b_channel <= DASR_RST_ENTRY0[DASR_CHB_MSB:DASR_CHB_LSB];
      converter_a_channel <= DASR_RST_ENTRY0[DASR_CHA_MSB:DASR_CHA_LSB];
    end else begin
      entry_index <= next_index;
      stack_return_flag <= next_return;
      converter_b_channel <= next_chb;
      converter_a_channel <= next_cha;
    end
  end

  // Checks
  logic after_rst;
  logic [35:0] entry_flat;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      after_rst <= 1'b0;
    end else begin
      after_rst <= 1'b1;
    end
  end

  always_comb begin
    entry_flat = {entry_q[3], entry_q[2], entry_q[1], entry_q[0]};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_dir_read_nostore: assert property ( // RULE_01
    reg_wr && !reg_wdata[DASR_DIR_BIT] |=> $stable(entry_flat))
    else $error("Write word with direction 0 changed an entry");

  a_dir_write_store: assert property ( // RULE_01
    reg_wr && reg_wdata[DASR_DIR_BIT] && reg_addr == DASR_ADDR_ENTRY2 &&
    reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == DASR_ADDR_ENTRY2
    |=> entry_q[2] == $past(reg_wdata[DASR_RET_BIT:0]))
    else $error("Write to entry two not stored");

  a_addr_field_gate: assert property ( // RULE_02
    reg_wr && reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] != reg_addr
    |=> $stable(entry_flat))
    else $error("Mismatched address field changed an entry");

  a_read_addr_echo: assert property ( // RULE_02
    reg_rd && reg_addr == DASR_ADDR_ENTRY3
    |=> reg_rdata == {1'b0, DASR_ADDR_ENTRY3, $past(entry_q[3])})
    else $error("Readback of entry three wrong");

  a_seq_advance: assert property ( // RULE_03
    conv_done && !stack_return_flag
    |=> entry_index == 2'($past(entry_index) + 2'h1))
    else $error("Sequencer did not advance");

  a_seq_return: assert property ( // RULE_04
    conv_done && stack_return_flag |=> entry_index == 2'h0)
    else $error("Sequencer did not return to first entry");

  a_chan_b_match: assert property ( // RULE_05
    converter_b_channel == entry_q[entry_index][DASR_CHB_MSB:DASR_CHB_LSB])
    else $error("Converter B channel differs from entry");

  a_chan_a_match: assert property ( // RULE_06
    converter_a_channel == entry_q[entry_index][DASR_CHA_MSB:DASR_CHA_LSB])
    else $error("Converter A channel differs from entry");

  a_entry_one_rst: assert property ( // RULE_07
    !after_rst |-> entry_q[1] == 9'h011)
    else $error("Entry one reset value wrong");

  a_entry_two_rst: assert property ( // RULE_08
    !after_rst |-> entry_q[2] == 9'h022)
    else $error("Entry two reset value wrong");

  a_entry_three_rst: assert property ( // RULE_09
    !after_rst |-> entry_q[3] == 9'h033)
    else $error("Entry three reset value wrong");

  a_entry_zero_rst: assert property ( // RULE_10
    !after_rst |-> entry_q[0] == 9'h000 && converter_a_channel == 4'h0)
    else $error("First entry reset value wrong");

  a_seq_hold_start: assert property ( // RULE_11
    (!after_rst |-> entry_index == 2'h0) and
    (!conv_done |=> $stable(entry_index)))
    else $error("Sequencer moved without completion or bad start");

  // Register bus: readback of entries zero to two and the idle read path
  a_read_entry_zero: assert property ( // RULE_10
    reg_rd && reg_addr == DASR_ADDR_ENTRY0
    |=> reg_rdata == {1'b0, DASR_ADDR_ENTRY0, $past(entry_q[0])})
    else $error("Readback of first entry wrong");

  a_read_entry_one: assert property ( // RULE_07
    reg_rd && reg_addr == DASR_ADDR_ENTRY1
    |=> reg_rdata == {1'b0, DASR_ADDR_ENTRY1, $past(entry_q[1])})
    else $error("Readback of entry one wrong");

  a_read_entry_two: assert property ( // RULE_08
    reg_rd && reg_addr == DASR_ADDR_ENTRY2
    |=> reg_rdata == {1'b0, DASR_ADDR_ENTRY2, $past(entry_q[2])})
    else $error("Readback of entry two wrong");

  a_read_unmapped_zero: assert property ( // RULE_02
    reg_rd && (reg_addr < DASR_ADDR_ENTRY0 || reg_addr > DASR_ADDR_ENTRY3)
    |=> reg_rdata == DASR_RDATA_NONE)
    else $error("Unmapped read returned data");

  a_read_field_addr: assert property ( // RULE_02
    reg_rd && (|addr_hit)
    |=> reg_rdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == $past(reg_addr))
    else $error("Readback address field differs from register");

  a_rdata_idle_zero: assert property ( // RULE_02
    !reg_rd |=> reg_rdata == DASR_RDATA_NONE)
    else $error("Read data stood without a read");

  a_read_dir_zero: assert property ( // RULE_01
    reg_rd |=> !reg_rdata[DASR_DIR_BIT])
    else $error("Direction bit read back as one");

  // Register bus: what a write may and may not change
  a_idle_keep_entries: assert property ( // RULE_01
    !reg_wr |=> $stable(entry_flat))
    else $error("Entry changed without a write");

  a_unmapped_wr_keep: assert property ( // RULE_02
    reg_wr && (reg_addr < DASR_ADDR_ENTRY0 || reg_addr > DASR_ADDR_ENTRY3)
    |=> $stable(entry_flat))
    else $error("Unmapped write changed an entry");

  a_write_entry_zero: assert property ( // RULE_10
    reg_wr && reg_wdata[DASR_DIR_BIT] && reg_addr == DASR_ADDR_ENTRY0 &&
    reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == DASR_ADDR_ENTRY0
    |=> entry_q[0] == $past(reg_wdata[DASR_RET_BIT:0]))
    else $error("Write to first entry not stored");

  a_write_entry_one: assert property ( // RULE_07
    reg_wr && reg_wdata[DASR_DIR_BIT] && reg_addr == DASR_ADDR_ENTRY1 &&
    reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == DASR_ADDR_ENTRY1
    |=> entry_q[1] == $past(reg_wdata[DASR_RET_BIT:0]))
    else $error("Write to entry one not stored");

  a_write_entry_three: assert property ( // RULE_09
    reg_wr && reg_wdata[DASR_DIR_BIT] && reg_addr == DASR_ADDR_ENTRY3 &&
    reg_wdata[DASR_ADDR_MSB:DASR_ADDR_LSB] == DASR_ADDR_ENTRY3
    |=> entry_q[3] == $past(reg_wdata[DASR_RET_BIT:0]))
    else $error("Write to entry three not stored");

  a_write_others_keep: assert property ( // RULE_02
    wr_ok && reg_addr == DASR_ADDR_ENTRY1
    |=> $stable(entry_q[0]) && $stable(entry_q[2]) && $stable(entry_q[3]))
    else $error("Write to entry one changed another entry");

  // Sequencer outputs against the stored entries
  a_flag_match: assert property ( // RULE_03 RULE_04
    stack_return_flag == entry_q[entry_index][DASR_RET_BIT])
    else $error("Return flag output differs from entry");

  a_chan_a_rewrite: assert property ( // RULE_06
    wr_ok && addr_hit[entry_index] && !conv_done
    |=> converter_a_channel == $past(reg_wdata[DASR_CHA_MSB:DASR_CHA_LSB]))
    else $error("Rewrite of current entry missed converter A");

  a_chan_b_rewrite: assert property ( // RULE_05
    wr_ok && addr_hit[entry_index] && !conv_done
    |=> converter_b_channel == $past(reg_wdata[DASR_CHB_MSB:DASR_CHB_LSB]))
    else $error("Rewrite of current entry missed converter B");

  a_chan_a_advance: assert property ( // RULE_03 RULE_06
    conv_done && !stack_return_flag && !wr_ok
    |=> converter_a_channel ==
      $past(entry_q[2'(entry_index + 2'h1)][DASR_CHA_MSB:DASR_CHA_LSB]))
    else $error("Converter A not taken from the next entry");

  a_return_chan_b: assert property ( // RULE_04 RULE_05
    conv_done && stack_return_flag && !wr_ok
    |=> converter_b_channel == $past(entry_q[0][DASR_CHB_MSB:DASR_CHB_LSB]))
    else $error("Converter B not taken from the first entry");

  a_seq_wrap_last: assert property ( // RULE_11
    conv_done && entry_index == 2'h3 |=> entry_index == 2'h0)
    else $error("Sequencer did not wrap after the last entry");

  a_rst_outputs_clear: assert property ( // RULE_10
    !after_rst |-> reg_rdata == DASR_RDATA_NONE && !stack_return_flag &&
      converter_b_channel == 4'h0)
    else $error("Outputs not clear after reset");

  c_return_taken: cover property (
    conv_done && stack_return_flag && entry_index != 2'h0);
  c_full_wrap: cover property (
    conv_done && entry_index == 2'h3 ##1 entry_index == 2'h0);
  c_write_hit: cover property (wr_ok && (|addr_hit));
  c_read_hit: cover property (reg_rd && (|addr_hit));
  c_write_refused: cover property (reg_wr && !wr_ok);

endmodule

// file: rtl/dasr_pkg.sv
package dasr_pkg;

  // Sequence stack geometry
  localparam int DASR_ENTRIES = 4;
  localparam int DASR_IDX_W = 2;
  localparam int DASR_WORD_W = 16;
  localparam int DASR_STORE_W = 9;

  // Entry word field positions
  localparam int DASR_DIR_BIT = 15;
  localparam int DASR_ADDR_MSB = 14;
  localparam int DASR_ADDR_LSB = 9;
  localparam int DASR_RET_BIT = 8;
  localparam int DASR_CHB_MSB = 7;
  localparam int DASR_CHB_LSB = 4;
  localparam int DASR_CHA_MSB = 3;
  localparam int DASR_CHA_LSB = 0;

  // Register addresses
  localparam logic [5:0] DASR_ADDR_ENTRY0 = 6'h20;
  localparam logic [5:0] DASR_ADDR_ENTRY1 = 6'h21;
  localparam logic [5:0] DASR_ADDR_ENTRY2 = 6'h22;
  localparam logic [5:0] DASR_ADDR_ENTRY3 = 6'h23;

  // Reset words, index is the entry number
  localparam logic [15:0] DASR_RST_ENTRY0 = 16'h4000;
  localparam logic [15:0] DASR_RST_ENTRY1 = 16'h4211;
  localparam logic [15:0] DASR_RST_ENTRY2 = 16'h4422;
  localparam logic [15:0] DASR_RST_ENTRY3 = 16'h4633;

  // Read data for an unmapped address
  localparam logic [15:0] DASR_RDATA_NONE = 16'h0000;

endpackage

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dasr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] entry_index;
  logic stack_return_flag;
  logic [3:0] converter_a_channel;
  logic [3:0] converter_b_channel;
  logic [15:0] rst_word [4] = '{DASR_RST_ENTRY0, DASR_RST_ENTRY1,
                                DASR_RST_ENTRY2, DASR_RST_ENTRY3};
  logic [15:0] mem [4];
  logic [1:0] cur;
  int n_errors = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  dasr_top dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .entry_index(entry_index),
    .stack_return_flag(stack_return_flag),
    .converter_a_channel(converter_a_channel),
    .converter_b_channel(converter_b_channel)
  );
  task automatic end_of_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] rb(input int i);
    return {1'b0, DASR_ADDR_ENTRY0 + 6'(i), mem[i][8:0]};
  endfunction
  task automatic check_state();
    check({5'h00, entry_index, stack_return_flag, converter_b_channel,
           converter_a_channel}, {5'h00, cur, mem[cur][8:0]});
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic read_all();
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(DASR_ADDR_ENTRY0 + 6'(i), d);
      check(d, rb(i));
    end
  endtask
  task automatic step();
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    cur = mem[cur][8] ? 2'd0 : cur + 2'd1;
    #1 check_state();
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) mem[i] = rst_word[i];
    cur = 2'd0;
    #1 check_state();
  endtask
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [15:0] d;
    do_reset();
    read_all();
    // Read data of the last read must be gone one cycle later
    @(posedge clk);
    #1 check(reg_rdata, DASR_RDATA_NONE);
    rd(6'h24, d);
    check(d, DASR_RDATA_NONE);
    // Direction bit clear, then address field naming another register
    wr(DASR_ADDR_ENTRY1, 16'h43ff);
    wr(DASR_ADDR_ENTRY1, 16'hc5ff);
    wr(6'h24, {1'b1, 6'h24, 9'h1ff});
    read_all();
    for (int i = 0; i < 4; i++) begin
      mem[i] = {1'b1, DASR_ADDR_ENTRY0 + 6'(i), i == 2, 4'hf - 4'(i),
                4'h8 + 4'(i)};
      wr(DASR_ADDR_ENTRY0 + 6'(i), mem[i]);
    end
    read_all();
    repeat (3) step();
    mem[2][8] = 1'b0;
    wr(DASR_ADDR_ENTRY2, mem[2]);
    repeat (4) step();
    // Rewrite of the entry in use reaches the channel outputs
    mem[0] = {1'b1, DASR_ADDR_ENTRY0, 9'h0c7};
    wr(DASR_ADDR_ENTRY0, mem[0]);
    repeat (2) @(posedge clk);
    #1 check_state();
    @(posedge clk);
    do_reset();
    read_all();
    end_of_test();
  end
endmodule
